// File: design/vib_ctrl_pkg.sv
// Purpose: Shared constants and types for the vibration module control-pin block.
// Assumes: 50 MHz core clock, 16-bit register port with word-indexed addresses.
// Notes: Every offset, field position, control-register reset value and cycle count lives here.
package vib_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register port geometry and offsets.
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] MISC_CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] ALARM_CTRL_OFS = 4'h1;
  localparam logic [ADDR_W-1:0] GLOBAL_CMD_OFS = 4'h2;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h3;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 4'h5;

  // ----------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------
  localparam int TRIG_EN_BIT = 12;
  localparam int MODE_LSB = 0;
  localparam int ALARM_FIRST_EN_BIT = 0;
  localparam int ALARM_FIRST_POL_BIT = 1;
  localparam int ALARM_SECOND_EN_BIT = 2;
  localparam int ALARM_SECOND_POL_BIT = 3;
  localparam int STAT_IDLE_BIT = 0;
  localparam int STAT_SHUTDOWN_BIT = 1;
  localparam int STAT_TRIG_BIT = 2;
  localparam int STAT_RUN_BIT = 3;
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ABORT_BIT = 1;
  localparam int IRQ_OVERTEMP_BIT = 2;
  localparam int IRQ_TRIGGER_BIT = 3;
  localparam logic [DATA_W-1:0] MISC_CTRL_RST = 16'h0000;
  localparam logic [DATA_W-1:0] ALARM_CTRL_RST = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  // ----------------------------------------------------------------
  // Command values for the global command register.
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] CMD_CAPTURE = 16'h0800;
  localparam logic [DATA_W-1:0] CMD_ESCAPE = 16'h00E8;
  localparam logic [DATA_W-1:0] CMD_FLASH_SAVE = 16'h0008;

  // ----------------------------------------------------------------
  // Timing, derived from the clock period.
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int TRIG_MIN_PULSE_NS = 50;
  localparam int TRIG_MIN_PULSE_CYC = (TRIG_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECORD_TIME_NS = 40000;
  localparam int RECORD_CYC = (RECORD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UNLOAD_TIME_NS = 2000;
  localparam int UNLOAD_CYC = (UNLOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // Nonvolatile store layout and pin synchroniser layout.
  // ----------------------------------------------------------------
  localparam int FLASH_DEPTH = 2;
  localparam logic FLASH_MISC_IDX = 1'b0;
  localparam logic FLASH_ALARM_IDX = 1'b1;
  localparam int SYNC_W = 3;
  localparam int SYNC_TRIG = 0;
  localparam int SYNC_HWRST = 1;
  localparam int SYNC_CS = 2;
  localparam logic [SYNC_W-1:0] SYNC_RST = 3'h6;

  typedef enum logic [1:0] {
    MANUAL_TIME_CAPTURE_MODE = 2'h0,
    MANUAL_SPECTRUM_MODE = 2'h1,
    AUTOMATIC_SPECTRUM_MODE = 2'h2,
    STREAMING_MODE = 2'h3
  } mode_t;

  typedef enum logic [8:0] {
    ST_LOAD_A = 9'h001,
    ST_LOAD_B = 9'h002,
    ST_LOAD_C = 9'h004,
    ST_IDLE = 9'h008,
    ST_CAPTURE = 9'h010,
    ST_UNLOAD = 9'h020,
    ST_SAVE_A = 9'h040,
    ST_SAVE_B = 9'h080,
    ST_HALT = 9'h100
  } state_t;

endpackage : vib_ctrl_pkg

// File: design/pin_sync.sv
// Purpose: Two-flop synchroniser for a group of asynchronous pins.
// Assumes: Each bit is an independent level; no bus coherence is needed.
// Notes: The first stage feeds only the second stage.
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] stage_q;

  // Both stages reset to the idle level of each pin.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stage_q <= RESET_VAL;
      pinSync <= RESET_VAL;
    end else begin
      stage_q <= pinIn;
      pinSync <= stage_q;
    end
  end

endmodule : pin_sync

// File: design/param_store.sv
// Purpose: Small nonvolatile parameter store with registered read data.
// Assumes: Only the power-on reset clears it; the hardware reset pin does not.
// Notes: Read data appear one cycle after the address.
module param_store #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2,
  parameter int AW = 1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic wrEn,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wrData,
  output logic [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // Power-on clears the store; hardware reset keeps it, which is its purpose.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      rdData <= '0;
    end else begin
      if (wrEn) begin
        mem_q[addr] <= wrData;
      end
      rdData <= mem_q[addr];
    end
  end

endmodule : param_store

// File: design/vib_ctrl_pins.sv
// Purpose: Control-pin logic of the vibration module: trigger, busy, alarms, monitor, reset.
// Assumes: Single 50 MHz clock; trigger, reset and chip-select pins pass a two-flop synchroniser first.
// Notes: Register port is word indexed; read data stand one cycle after the strobe.
//
// The address-and-strobe port and the register addresses were left to the implementer.
module vib_ctrl_pins
  import vib_ctrl_pkg::*;
#(
  parameter int RECORD_CYCLES = RECORD_CYC,
  parameter int UNLOAD_CYCLES = UNLOAD_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [DATA_W-1:0] regRdData,
  input wire logic triggerIn,
  input wire logic hwResetN,
  input wire logic chipSelN,
  input wire logic txBitIn,
  input wire logic overTempIn,
  input wire logic alarmCondFirst,
  input wire logic alarmCondSecond,
  output logic busyReadyOut,
  output logic alarmOutFirst,
  output logic alarmOutFirstOe,
  output logic alarmOutSecond,
  output logic alarmOutSecondOe,
  output logic supplyMonitorOutput,
  output logic serialDataOut,
  output logic serialDataOutOe,
  output logic irqOut
);

  // ----------------------------------------------------------------
  // Pin synchronisation and internal reset.
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pinSync;
  logic trigLevel, hwRstActive, csSyncN, coreRst;

  // Trigger, reset and chip select all arrive from outside the clock domain.
  pin_sync #(.WIDTH(SYNC_W), .RESET_VAL(SYNC_RST)) u_pin_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pinIn({chipSelN, hwResetN, triggerIn}),
    .pinSync(pinSync)
  );

  assign trigLevel = pinSync[SYNC_TRIG];
  assign hwRstActive = ~pinSync[SYNC_HWRST];
  assign csSyncN = pinSync[SYNC_CS];
  // The reset pin clears all working state but not the parameter store or the shutdown latch.
  assign coreRst = sys_rst | hwRstActive;

  // ----------------------------------------------------------------
  // State, registers and decode of mode, access and requests.
  // ----------------------------------------------------------------
  state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [DATA_W-1:0] miscCtrl_q, alarmCtrl_q, flashWrData, flashRdData;
  logic [IRQ_W-1:0] irqStatus_q, irqMask_q, irqEvent;
  logic trigPrev_q, runCmd_q, shutdown_q, flashWe, flashAddr;
  mode_t mode;
  logic streaming, manualMode, runMode, idle, refuse, escWr, wrOk, cmdWr;
  logic trigEn, trigRise, captureReq, runReq, saveReq, recordDone, unloadDone;

  assign mode = mode_t'(miscCtrl_q[MODE_LSB +: 2]);
  assign streaming = (mode == STREAMING_MODE);
  assign manualMode = (mode == MANUAL_TIME_CAPTURE_MODE) | (mode == MANUAL_SPECTRUM_MODE);
  assign runMode = (mode == AUTOMATIC_SPECTRUM_MODE) | streaming;
  assign idle = (state_q == ST_IDLE);
  // Outside streaming the port is closed while anything but idle runs.
  assign refuse = ~streaming & ~idle;
  // The escape write bypasses the refusal so a long capture can be cut short.
  assign escWr = regWrStb & (regAddr == GLOBAL_CMD_OFS) & (regWrData == CMD_ESCAPE);
  assign wrOk = regWrStb & ~refuse;
  assign cmdWr = wrOk & (regAddr == GLOBAL_CMD_OFS);
  assign trigEn = miscCtrl_q[TRIG_EN_BIT];
  // Only a low-to-high change of the synchronised level counts as a trigger.
  assign trigRise = trigEn & trigLevel & ~trigPrev_q;
  // Pin edge and capture command are one and the same request.
  assign captureReq = manualMode & ((cmdWr & (regWrData == CMD_CAPTURE)) | trigRise);
  // With the pin enabled its level gates conversion, else the run command does.
  assign runReq = runMode & (trigEn ? trigLevel : runCmd_q);
  assign saveReq = cmdWr & (regWrData == CMD_FLASH_SAVE) & idle;
  assign recordDone = (cnt_q == CNT_W'(RECORD_CYCLES - 1));
  assign unloadDone = (cnt_q == CNT_W'(UNLOAD_CYCLES - 1));

  // ----------------------------------------------------------------
  // Sequencer.
  // ----------------------------------------------------------------
  // Reload runs first after every reset, so nothing starts on stale settings.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_LOAD_A: state_d = ST_LOAD_B;
      ST_LOAD_B: state_d = ST_LOAD_C;
      ST_LOAD_C: state_d = ST_IDLE;
      ST_IDLE: begin
        if (shutdown_q) begin
          state_d = ST_HALT;
        end else if (saveReq) begin
          state_d = ST_SAVE_A;
        end else if (captureReq | runReq) begin
          state_d = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        if (escWr) begin
          state_d = ST_IDLE;
        end else if (shutdown_q) begin
          state_d = ST_HALT;
        end else if (recordDone) begin
          state_d = ST_UNLOAD;
        end
      end
      ST_UNLOAD: begin
        if (escWr) begin
          state_d = ST_IDLE;
        end else if (shutdown_q) begin
          state_d = ST_HALT;
        end else if (unloadDone) begin
          // A record in flight completes unless escaped or shut down; only then is the gate looked at.
          state_d = runReq ? ST_CAPTURE : ST_IDLE;
        end
      end
      ST_SAVE_A: state_d = ST_SAVE_B;
      ST_SAVE_B: state_d = ST_IDLE;
      ST_HALT: state_d = ST_HALT;
      default: state_d = ST_LOAD_A;
    endcase
  end

  // The counter restarts whenever the sequencer moves.
  assign cnt_d = (state_d != state_q) ? '0 : cnt_q + CNT_W'(1);

  // Sequencer state and phase counter.
  always_ff @(posedge core_clk) begin
    if (coreRst) begin
      state_q <= ST_LOAD_A;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Edge detector history and the software run gate.
  always_ff @(posedge core_clk) begin
    if (coreRst) begin
      trigPrev_q <= 1'b0;
      runCmd_q <= 1'b0;
    end else begin
      trigPrev_q <= trigLevel;
      if (escWr) begin
        runCmd_q <= 1'b0;
      end else if (cmdWr & (regWrData == CMD_CAPTURE) & runMode) begin
        runCmd_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Parameter store and configuration registers.
  // ----------------------------------------------------------------
  assign flashWe = (state_q == ST_SAVE_A) | (state_q == ST_SAVE_B);
  assign flashAddr = ((state_q == ST_LOAD_A) | (state_q == ST_SAVE_A)) ? FLASH_MISC_IDX : FLASH_ALARM_IDX;
  assign flashWrData = (state_q == ST_SAVE_A) ? miscCtrl_q : alarmCtrl_q;

  param_store #(.WIDTH(DATA_W), .DEPTH(FLASH_DEPTH), .AW(1)) u_param_store (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .wrEn(flashWe),
    .addr(flashAddr),
    .wrData(flashWrData),
    .rdData(flashRdData)
  );

  // Store data lag the address by one cycle, hence the B and C load slots.
  always_ff @(posedge core_clk) begin
    if (coreRst) begin
      miscCtrl_q <= MISC_CTRL_RST;
    end else if (state_q == ST_LOAD_B) begin
      miscCtrl_q <= flashRdData;
    end else if (wrOk & (regAddr == MISC_CTRL_OFS)) begin
      miscCtrl_q <= regWrData;
    end
  end

  // Alarm control is reloaded the cycle after control.
  always_ff @(posedge core_clk) begin
    if (coreRst) begin
      alarmCtrl_q <= ALARM_CTRL_RST;
    end else if (state_q == ST_LOAD_C) begin
      alarmCtrl_q <= flashRdData;
    end else if (wrOk & (regAddr == ALARM_CTRL_OFS)) begin
      alarmCtrl_q <= regWrData;
    end
  end

  // Shutdown latches until power-on reset; the reset pin cannot cool the die.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      shutdown_q <= 1'b0;
    end else if (overTempIn) begin
      shutdown_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, mask and output.
  // ----------------------------------------------------------------
  always_comb begin
    irqEvent = '0;
    irqEvent[IRQ_DONE_BIT] = (state_q == ST_UNLOAD) & unloadDone & ~escWr;
    irqEvent[IRQ_ABORT_BIT] = escWr & ((state_q == ST_CAPTURE) | (state_q == ST_UNLOAD));
    irqEvent[IRQ_OVERTEMP_BIT] = overTempIn & ~shutdown_q;
    irqEvent[IRQ_TRIGGER_BIT] = trigRise;
  end

  // A new event beats a write-one clear in the same cycle.
  always_ff @(posedge core_clk) begin
    if (coreRst) begin
      irqStatus_q <= '0;
    end else if (wrOk & (regAddr == IRQ_STATUS_OFS)) begin
      irqStatus_q <= (irqStatus_q & ~regWrData[IRQ_W-1:0]) | irqEvent;
    end else begin
      irqStatus_q <= irqStatus_q | irqEvent;
    end
  end

  // Mask register and the level interrupt built from it.
  always_ff @(posedge core_clk) begin
    if (coreRst) begin
      irqMask_q <= IRQ_MASK_RST;
      irqOut <= 1'b0;
    end else begin
      if (wrOk & (regAddr == IRQ_MASK_OFS)) begin
        irqMask_q <= regWrData[IRQ_W-1:0];
      end
      irqOut <= |(irqStatus_q & irqMask_q);
    end
  end

  // ----------------------------------------------------------------
  // Register read port.
  // ----------------------------------------------------------------
  // Reads refused while busy return zero; data stand for one cycle only.
  always_ff @(posedge core_clk) begin
    if (coreRst) begin
      regRdData <= '0;
    end else if (regRdStb & ~refuse) begin
      unique case (regAddr)
        MISC_CTRL_OFS: regRdData <= miscCtrl_q;
        ALARM_CTRL_OFS: regRdData <= alarmCtrl_q;
        STATUS_OFS: regRdData <= DATA_W'({runCmd_q, trigLevel, shutdown_q, idle});
        IRQ_STATUS_OFS: regRdData <= DATA_W'(irqStatus_q);
        IRQ_MASK_OFS: regRdData <= DATA_W'(irqMask_q);
        default: regRdData <= '0;
      endcase
    end else begin
      regRdData <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs.
  // ----------------------------------------------------------------
  // Busy pin: ready flag in streaming, idle flag in every other mode.
  always_ff @(posedge core_clk) begin
    if (coreRst) begin
      busyReadyOut <= 1'b0;
    end else if (streaming) begin
      busyReadyOut <= ~((state_q == ST_UNLOAD) | (state_q == ST_HALT));
    end else begin
      busyReadyOut <= idle;
    end
  end

  // Alarm pins let go in streaming mode so the pins carry no stale alarm.
  always_ff @(posedge core_clk) begin
    if (coreRst) begin
      alarmOutFirst <= 1'b0;
      alarmOutFirstOe <= 1'b0;
      alarmOutSecond <= 1'b0;
      alarmOutSecondOe <= 1'b0;
    end else begin
      alarmOutFirstOe <= ~streaming;
      alarmOutSecondOe <= ~streaming;
      alarmOutFirst <= ~streaming & ((alarmCtrl_q[ALARM_FIRST_EN_BIT] & alarmCondFirst)
                                     ^ alarmCtrl_q[ALARM_FIRST_POL_BIT]);
      alarmOutSecond <= ~streaming & ((alarmCtrl_q[ALARM_SECOND_EN_BIT] & alarmCondSecond)
                                      ^ alarmCtrl_q[ALARM_SECOND_POL_BIT]);
    end
  end

  // Supply monitor follows the shutdown latch; high in normal operation.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      supplyMonitorOutput <= 1'b1;
    end else begin
      supplyMonitorOutput <= ~shutdown_q;
    end
  end

  // Serial data output enable tracks the synchronised chip select.
  always_ff @(posedge core_clk) begin
    if (coreRst) begin
      serialDataOut <= 1'b0;
      serialDataOutOe <= 1'b0;
    end else begin
      serialDataOutOe <= ~csSyncN;
      serialDataOut <= ~csSyncN & txBitIn;
    end
  end

endmodule : vib_ctrl_pins

// File: test/vib_ctrl_pins_props.sv
// Purpose: Port-level checks of the control-pin block.
// Assumes: Mode is tracked from control writes taken while the port is open.
// Notes: Only the streaming or non-streaming split of the mode is tracked.
module vib_ctrl_pins_props
  import vib_ctrl_pkg::*;
#(
  parameter int RECORD_CYCLES = RECORD_CYC,
  parameter int UNLOAD_CYCLES = UNLOAD_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [DATA_W-1:0] regRdData,
  input wire logic hwResetN,
  input wire logic chipSelN,
  input wire logic txBitIn,
  input wire logic overTempIn,
  input wire logic busyReadyOut,
  input wire logic alarmOutFirstOe,
  input wire logic alarmOutSecondOe,
  input wire logic supplyMonitorOutput,
  input wire logic serialDataOut,
  input wire logic serialDataOutOe
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  localparam int DONE_LO = RECORD_CYCLES + UNLOAD_CYCLES;
  localparam int DONE_HI = DONE_LO + 4;
  logic strQ;
  logic capW;
  logic escW;
  // Command writes seen on the port.
  assign capW = regWrStb && regAddr == GLOBAL_CMD_OFS && regWrData == CMD_CAPTURE;
  assign escW = regWrStb && regAddr == GLOBAL_CMD_OFS && regWrData == CMD_ESCAPE;
  // Refused writes must not move the tracked mode, so only open-port writes count.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      strQ <= 1'b0;
    end else if (regWrStb && regAddr == MISC_CTRL_OFS && (busyReadyOut || strQ)) begin
      strQ <= regWrData[MODE_LSB +: 2] == STREAMING_MODE;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  capture_start_a: assert property (capW && busyReadyOut && supplyMonitorOutput && !strQ
    |-> ##2 !busyReadyOut [*8]) else $error("capture command did not hold busy");
  capture_end_a: assert property (capW && busyReadyOut && supplyMonitorOutput && !strQ
    |-> ##[DONE_LO:DONE_HI] busyReadyOut) else $error("busy did not rise after the record");
  escape_ends_a: assert property (escW && supplyMonitorOutput
    |-> ##[1:8] (busyReadyOut || !hwResetN || !supplyMonitorOutput)) else $error("escape did not end work");
  temp_shutdown_a: assert property (overTempIn |=> ##1 !supplyMonitorOutput)
    else $error("monitor pin did not fall");
  monitor_stuck_a: assert property (!supplyMonitorOutput |=> !supplyMonitorOutput)
    else $error("monitor pin recovered without reset");
  cs_release_a: assert property (chipSelN [*4] |-> !serialDataOutOe)
    else $error("data out driven while deselected");
  data_quiet_a: assert property (!serialDataOutOe |-> !serialDataOut)
    else $error("data out not quiet");
  data_echo_a: assert property (serialDataOutOe |-> serialDataOut == $past(txBitIn))
    else $error("data out does not follow bit in");
  read_idle_a: assert property (!regRdStb |=> regRdData == 16'h0000)
    else $error("read data outside read slot");
  alarm_quiet_a: assert property (strQ [*3] |-> !alarmOutFirstOe && !alarmOutSecondOe)
    else $error("alarm driven in streaming");
endmodule : vib_ctrl_pins_props

bind vib_ctrl_pins vib_ctrl_pins_props #(.RECORD_CYCLES(RECORD_CYCLES), .UNLOAD_CYCLES(UNLOAD_CYCLES)) props_u (
  .core_clk, .sys_rst, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .hwResetN, .chipSelN,
  .txBitIn, .overTempIn, .busyReadyOut, .alarmOutFirstOe, .alarmOutSecondOe, .supplyMonitorOutput,
  .serialDataOut, .serialDataOutOe);

// File: test/host_pins.sv
// Purpose: Host model driving the trigger and hardware reset pins.
// Assumes: The host changes its pins just after a rising clock edge.
// Notes: Short trigger requests are stretched, never sent short.
module host_pins
  import vib_ctrl_pkg::*;
(
  input wire logic core_clk,
  output logic triggerIn = 1'b0,
  output logic hwResetN = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Pin tasks
  // ----------------------------------------------------------------
  // Level on the trigger pin, used as a gate in the run modes.
  task automatic setTrig(input logic lvl);
    @(posedge core_clk);
    triggerIn <= lvl;
  endtask : setTrig
  // Pulses below the minimum width would be missed, so the width is clamped up.
  task automatic pulseTrig(input int n);
    setTrig(1'b1);
    repeat (n < TRIG_MIN_PULSE_CYC ? TRIG_MIN_PULSE_CYC : n) @(posedge core_clk);
    triggerIn <= 1'b0;
  endtask : pulseTrig
  // Active-low reset pulse held for n cycles.
  task automatic pulseReset(input int n);
    @(posedge core_clk);
    hwResetN <= 1'b0;
    repeat (n) @(posedge core_clk);
    hwResetN <= 1'b1;
  endtask : pulseReset
endmodule : host_pins

// File: test/vib_ctrl_pins_tb.sv
// Purpose: Self-checking bench for the control-pin block.
// Assumes: Record and unload counts are shortened to 8 and 4 cycles.
// Notes: Every wait is bounded; a timeout ends the run as a failure.
module vib_ctrl_pins_tb
  import vib_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Stimulus and checks
  // ----------------------------------------------------------------
  localparam logic [15:0] TE = 16'h0001 << TRIG_EN_BIT;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData;
  logic chipSelN, txBitIn, overTempIn, alarmCondFirst, alarmCondSecond;
  logic triggerIn, hwResetN, busyReadyOut, alarmOutFirst, alarmOutFirstOe, alarmOutSecond;
  logic alarmOutSecondOe, supplyMonitorOutput, serialDataOut, serialDataOutOe, irqOut;
  int mismatches = 0;
  int comparisons = 0;
  // Free-running core clock.
  always #10 core_clk = ~core_clk;
  host_pins host_u (.core_clk, .triggerIn, .hwResetN);
  vib_ctrl_pins #(.RECORD_CYCLES(8), .UNLOAD_CYCLES(4)) dut_u (
    .core_clk, .sys_rst, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .triggerIn, .hwResetN,
    .chipSelN, .txBitIn, .overTempIn, .alarmCondFirst, .alarmCondSecond, .busyReadyOut, .alarmOutFirst,
    .alarmOutFirstOe, .alarmOutSecond, .alarmOutSecondOe, .supplyMonitorOutput, .serialDataOut,
    .serialDataOutOe, .irqOut);
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Bus cycles end on a falling edge so later samples see settled outputs.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge core_clk);
    regWrStb <= 1'b0;
    @(negedge core_clk);
  endtask : wr
  task automatic rdc(input string nm, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge core_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge core_clk);
    regRdStb <= 1'b0;
    @(negedge core_clk);
    chk(nm, regRdData, exp);
  endtask : rdc
  task automatic waitBusy(input logic lvl, input int lim);
    for (int n = 0; n < lim; n++) begin
      @(negedge core_clk);
      if (busyReadyOut === lvl) break;
    end
    if (busyReadyOut !== lvl) begin
      chk("busy wait", 16'(busyReadyOut), 16'(lvl));
      print_verdict();
    end
  endtask : waitBusy
  task automatic testCapture();
    rdc("unmapped", 4'hF, 16'h0000);
    wr(IRQ_MASK_OFS, 16'h0001 << IRQ_DONE_BIT);
    wr(GLOBAL_CMD_OFS, CMD_CAPTURE);
    waitBusy(1'b0, 4);
    rdc("busy read", STATUS_OFS, 16'h0000);
    wr(MISC_CTRL_OFS, 16'h0001);
    waitBusy(1'b1, 20);
    rdc("busy write", MISC_CTRL_OFS, MISC_CTRL_RST);
    chk("irq raised", 16'(irqOut), 16'h0001);
    wr(IRQ_MASK_OFS, 16'h0000);
    @(negedge core_clk);
    chk("irq masked", 16'(irqOut), 16'h0000);
    wr(IRQ_STATUS_OFS, 16'h000F);
    rdc("irq cleared", IRQ_STATUS_OFS, 16'h0000);
    $display("test capture done");
  endtask : testCapture
  task automatic testTrigger();
    host_u.pulseTrig(3);
    repeat (6) @(negedge core_clk);
    chk("trigger off", 16'(busyReadyOut), 16'h0001);
    for (int m = 0; m < 2; m++) begin
      wr(MISC_CTRL_OFS, TE | 16'(m));
      host_u.setTrig(1'b1);
      waitBusy(1'b0, 8);
      waitBusy(1'b1, 20);
      repeat (8) @(negedge core_clk);
      chk("static level", 16'(busyReadyOut), 16'h0001);
      host_u.setTrig(1'b0);
    end
    wr(IRQ_STATUS_OFS, 16'h000F);
    host_u.pulseTrig(1);
    waitBusy(1'b0, 10);
    wr(GLOBAL_CMD_OFS, CMD_ESCAPE);
    waitBusy(1'b1, 3);
    rdc("abort", IRQ_STATUS_OFS, (16'h0001 << IRQ_ABORT_BIT) | (16'h0001 << IRQ_TRIGGER_BIT));
    $display("test trigger done");
  endtask : testTrigger
  task automatic testRunModes();
    wr(ALARM_CTRL_OFS, 16'h000D);
    repeat (3) @(negedge core_clk);
    chk("alarm pins", 16'({alarmOutFirstOe, alarmOutFirst, alarmOutSecondOe, alarmOutSecond}), 16'h000E);
    @(posedge core_clk);
    alarmCondFirst <= 1'b0;
    alarmCondSecond <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk("alarm clear", 16'({alarmOutFirstOe, alarmOutFirst, alarmOutSecondOe, alarmOutSecond}), 16'h000B);
    wr(MISC_CTRL_OFS, TE | 16'h0002);
    host_u.setTrig(1'b1);
    waitBusy(1'b0, 8);
    repeat (30) @(negedge core_clk);
    chk("records repeat", 16'(busyReadyOut), 16'h0000);
    host_u.setTrig(1'b0);
    waitBusy(1'b1, 20);
    wr(MISC_CTRL_OFS, TE | 16'h0003);
    repeat (3) @(negedge core_clk);
    chk("alarm off", 16'({alarmOutFirstOe, alarmOutSecondOe}), 16'h0000);
    host_u.setTrig(1'b1);
    waitBusy(1'b0, 16);
    waitBusy(1'b1, 8);
    rdc("open port", MISC_CTRL_OFS, TE | 16'h0003);
    host_u.setTrig(1'b0);
    repeat (20) @(negedge core_clk);
    wr(MISC_CTRL_OFS, 16'h0000);
    $display("test run modes done");
  endtask : testRunModes
  task automatic testPinsReset();
    @(posedge core_clk);
    chipSelN <= 1'b0;
    txBitIn <= 1'b1;
    repeat (5) @(negedge core_clk);
    chk("serial out", 16'({serialDataOutOe, serialDataOut}), 16'h0003);
    @(posedge core_clk);
    chipSelN <= 1'b1;
    wr(MISC_CTRL_OFS, TE | 16'h0001);
    wr(IRQ_MASK_OFS, 16'h0004);
    wr(GLOBAL_CMD_OFS, CMD_FLASH_SAVE);
    waitBusy(1'b0, 4);
    waitBusy(1'b1, 10);
    wr(MISC_CTRL_OFS, 16'h0000);
    host_u.pulseReset(4);
    @(negedge core_clk);
    waitBusy(1'b1, 12);
    rdc("reload", MISC_CTRL_OFS, TE | 16'h0001);
    rdc("known state", IRQ_MASK_OFS, 16'(IRQ_MASK_RST));
    @(posedge core_clk);
    overTempIn <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk("shutdown", 16'(supplyMonitorOutput), 16'h0000);
    $display("test pins and reset done");
  endtask : testPinsReset
  // Main sequence: reset long enough to flush the pin synchronisers.
  initial begin
    regAddr <= '0;
    regWrData <= '0;
    chipSelN <= 1'b1;
    txBitIn <= 1'b0;
    overTempIn <= 1'b0;
    alarmCondFirst <= 1'b1;
    alarmCondSecond <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    waitBusy(1'b1, 12);
    testCapture();
    testTrigger();
    testRunModes();
    testPinsReset();
    print_verdict();
  end
endmodule : vib_ctrl_pins_tb
